// >>> src/cssop_core.sv
`timescale 1ns/100ps
`include "cssop_defs.svh"
module cssop_core
    import cssop_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // axi4-lite write channels
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read channels
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // data memory holding the stack
    output logic memReq,
    output cssop_mreq_t memCmd,
    input wire logic [15:0] memRdata,
    input wire logic memAck,
    // watchdog guard
    output logic wdtViolation
);

// ---------------------------------------------------------------
// declarations
// ---------------------------------------------------------------
logic awHeld;
logic wHeld;
logic [7:0] awAddr;
logic [31:0] wData;
logic [3:0] wStrb;
logic wrFire;
logic wrMapped;
logic rdMapped;
logic [31:0] rdValue;
cssop_state_t state;
cssop_cmd_t cmd;
cssop_cmd_t newCmd;
logic [15:0] operand;
logic [15:0] sp;
logic [15:0] pc;
logic [15:0] sr;
logic [15:0] result;
logic wdtSticky;
logic startFire;
logic wdtHit;
logic [15:0] shRes;
logic [15:0] shSr;
logic [7:0] hiKeep;
logic [7:0] res8;
logic [15:0] res16;
logic oldMsb;
logic shC;
logic shV;
logic [15:0] popVal;
logic [15:0] pushVal;

// merge enabled low byte lanes into a register
function automatic logic [15:0] merge16(input logic [15:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [15:0] m;
    m = old;
    if (strb[0]) begin
        m[7:0] = data[7:0];
    end
    if (strb[1]) begin
        m[15:8] = data[15:8];
    end
    return m;
endfunction

// ---------------------------------------------------------------
// bus slave, write side
// ---------------------------------------------------------------
// address and data taken in either order, held until both
assign s_axi_awready = !awHeld;
assign s_axi_wready = !wHeld;
assign wrFire = awHeld && wHeld && !s_axi_bvalid;

always_comb begin
    case (awAddr)
        `CS_REG_CTRL, `CS_REG_OPND, `CS_REG_SP, `CS_REG_PC,
        `CS_REG_SR, `CS_REG_RES, `CS_REG_STAT: wrMapped = 1'b1;
        default: wrMapped = 1'b0;
    endcase
end

// capture write address
always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        awHeld <= 1'b0;
        awAddr <= 8'h00;
    end else if (s_axi_awvalid && !awHeld) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
    end else if (wrFire) begin
        awHeld <= 1'b0;
    end
end

// capture write data
always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        wHeld <= 1'b0;
        wData <= 32'h0000_0000;
        wStrb <= 4'h0;
    end else if (s_axi_wvalid && !wHeld) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
    end else if (wrFire) begin
        wHeld <= 1'b0;
    end
end

// write response; unmapped offsets answer slverr
always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `CS_RESP_OKAY;
    end else if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `CS_RESP_OKAY : `CS_RESP_SLVERR;
    end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
    end
end

// operand register, writable at any time
always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        operand <= 16'h0000;
    end else if (wrFire && awAddr == `CS_REG_OPND) begin
        operand <= merge16(operand, wData, wStrb);
    end
end

// ---------------------------------------------------------------
// bus slave, read side
// ---------------------------------------------------------------
assign s_axi_arready = !s_axi_rvalid;

always_comb begin
    rdMapped = 1'b1;
    rdValue = 32'h0000_0000;
    case (s_axi_araddr)
        `CS_REG_CTRL: rdValue = {27'h0000000, cmd};
        `CS_REG_OPND: rdValue = {16'h0000, operand};
        `CS_REG_SP: rdValue = {16'h0000, sp};
        `CS_REG_PC: rdValue = {16'h0000, pc};
        `CS_REG_SR: rdValue = {16'h0000, sr};
        `CS_REG_RES: rdValue = {16'h0000, result};
        `CS_REG_STAT: rdValue = {30'h00000000, wdtSticky, memReq};
        default: rdMapped = 1'b0;
    endcase
end

// read answer registered on the same edge that takes the address
always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `CS_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdValue;
        s_axi_rresp <= rdMapped ? `CS_RESP_OKAY : `CS_RESP_SLVERR;
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

// ---------------------------------------------------------------
// shift datapath
// ---------------------------------------------------------------
assign newCmd = cssop_cmd_t'({wData[`CS_CTRL_DREG], wData[`CS_CTRL_BYTE],
                              wData[2:0]});
// a start while busy is dropped so the stack walk stays atomic
assign startFire = wrFire && awAddr == `CS_REG_CTRL && wStrb[3]
                   && wData[`CS_CTRL_START] && state == ST_IDLE;

always_comb begin
    // memory destination keeps the upper byte
    // [RULE_19] upper byte cleared
    hiKeep = newCmd.destReg ? `CS_HI_CLEAR : operand[15:8];
    oldMsb = newCmd.byteOp ? operand[7] : operand[15];
    case (newCmd.op)
        // [RULE_12] shift in zero
        OP_RLA: begin
            res16 = {operand[14:0], 1'b0};
            res8 = {operand[6:0], 1'b0};
        end
        // [RULE_16] carry into lsb
        OP_RLC: begin
            res16 = {operand[14:0], sr[`CS_BIT_C]};
            res8 = {operand[6:0], sr[`CS_BIT_C]};
        end
        // [RULE_17] sign kept and copied
        OP_RRA: begin
            res16 = {operand[15], operand[15:1]};
            res8 = {operand[7], operand[7:1]};
        end
        default: begin
            res16 = operand;
            res8 = operand[7:0];
        end
    endcase
    shRes = newCmd.byteOp ? {hiKeep, res8} : res16;
    // [RULE_15] carry from old msb
    shC = (newCmd.op == OP_RRA) ? operand[0] : oldMsb;
    // [RULE_13] word overflow window
    // [RULE_14] byte overflow window
    if (newCmd.op == OP_RRA) begin
        shV = 1'b0;
    end else if (newCmd.byteOp) begin
        shV = operand[7:0] >= `CS_OVF_LO_B
              && operand[7:0] < `CS_OVF_HI_B;
    end else begin
        shV = operand >= `CS_OVF_LO_W && operand < `CS_OVF_HI_W;
    end
    // [RULE_07] mode bits carried over
    shSr = sr;
    shSr[`CS_BIT_C] = shC;
    shSr[`CS_BIT_V] = shV;
    // [RULE_18] n and z from result
    shSr[`CS_BIT_N] = newCmd.byteOp ? shRes[7] : shRes[15];
    shSr[`CS_BIT_Z] = newCmd.byteOp ? (shRes[7:0] == 8'h00)
                                    : (shRes == 16'h0000);
end

// [RULE_02] byte pop to register
assign popVal = !cmd.byteOp ? memRdata
              : {cmd.destReg ? `CS_HI_CLEAR : operand[15:8],
                 memRdata[7:0]};
// byte push stores {00, low byte}
assign pushVal = newCmd.byteOp ? {`CS_HI_CLEAR, operand[7:0]} : operand;

// ---------------------------------------------------------------
// stack engine
// ---------------------------------------------------------------
assign memReq = state != ST_IDLE;

// stack pointer, counter and status writes land only when idle, so software cannot tear
// a stack walk in progress
always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        state <= ST_IDLE;
        cmd <= cssop_cmd_t'(5'h07);
        sp <= `CS_SP_RST;
        pc <= `CS_PC_RST;
        sr <= `CS_SR_RST;
        result <= 16'h0000;
        memCmd <= '0;
    end else begin
        case (state)
            ST_IDLE: begin
                if (startFire) begin
                    cmd <= newCmd;
                    case (newCmd.op)
                        OP_POP, OP_RET, OP_INTERRUPT_RETURN: begin
                            memCmd <= '{1'b0, sp, 16'h0000};
                            state <= ST_READ;
                        end
                        // [RULE_04] decrement before write
                        // [RULE_05] always two
                        OP_PUSH: begin
                            sp <= sp - `CS_SP_STEP;
                            memCmd <= '{1'b1, sp - `CS_SP_STEP, pushVal};
                            state <= ST_WRITE;
                        end
                        OP_RLA, OP_RLC, OP_RRA: begin
                            result <= shRes;
                            sr <= shSr;
                        end
                        default: begin
                            state <= ST_IDLE;
                        end
                    endcase
                end else if (wrFire) begin
                    case (awAddr)
                        `CS_REG_SP: sp <= merge16(sp, wData, wStrb);
                        `CS_REG_PC: pc <= merge16(pc, wData, wStrb);
                        `CS_REG_SR: sr <= merge16(sr, wData, wStrb);
                        default: state <= ST_IDLE;
                    endcase
                end
            end
            ST_READ: begin
                if (memAck) begin
                    // [RULE_01] read then step
                    // [RULE_03] always two
                    sp <= sp + `CS_SP_STEP;
                    state <= ST_IDLE;
                    case (cmd.op)
                        // [RULE_06] flags untouched
                        OP_POP: begin
                            result <= popVal;
                        end
                        // [RULE_08] pc from stack
                        OP_RET: begin
                            pc <= memRdata;
                        end
                        // [RULE_09] status first
                        // [RULE_11] whole status word
                        OP_INTERRUPT_RETURN: begin
                            sr <= memRdata;
                            memCmd.addr <= sp + `CS_SP_STEP;
                            state <= ST_READ2;
                        end
                        default: begin
                            state <= ST_IDLE;
                        end
                    endcase
                end
            end
            // [RULE_10] pc from new top
            ST_READ2: begin
                if (memAck) begin
                    pc <= memRdata;
                    sp <= sp + `CS_SP_STEP;
                    state <= ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (memAck) begin
                    state <= ST_IDLE;
                end
            end
            default: begin
                state <= ST_IDLE;
            end
        endcase
    end
end

// ---------------------------------------------------------------
// watchdog guard
// ---------------------------------------------------------------
// counts even a write that rewrites the same value
// [RULE_20] keyless write detect
assign wdtHit = memReq && memCmd.write && memAck
                && memCmd.addr == `CS_WDT_ADDR
                && memCmd.wdata[15:8] != `CS_WDT_KEY;

// pulse plus sticky flag; a new hit wins over a clear
always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        wdtViolation <= 1'b0;
        wdtSticky <= 1'b0;
    end else begin
        wdtViolation <= wdtHit;
        if (wdtHit) begin
            wdtSticky <= 1'b1;
        end else if (wrFire && awAddr == `CS_REG_STAT && wStrb[0]
                     && wData[`CS_STAT_WDT]) begin
            wdtSticky <= 1'b0;
        end
    end
end

// ---------------------------------------------------------------
// assertions
// ---------------------------------------------------------------
a_pop_step: assert property ( // [RULE_01]
    @(posedge clk_sys) disable iff (!reset_n)
    state == ST_READ && memAck && cmd.op == OP_POP
    |=> sp == $past(sp) + `CS_SP_STEP && result == $past(popVal))
    else $error("pop did not load result and step pointer by two");

a_pop_byte_hi: assert property ( // [RULE_02]
    @(posedge clk_sys) disable iff (!reset_n)
    state == ST_READ && memAck && cmd.op == OP_POP && cmd.byteOp
    && cmd.destReg |=> result[15:8] == 8'h00
    && result[7:0] == $past(memRdata[7:0]))
    else $error("byte pop to register kept a high byte");

a_push_order: assert property ( // [RULE_04]
    @(posedge clk_sys) disable iff (!reset_n)
    startFire && newCmd.op == OP_PUSH
    |=> sp == $past(sp) - `CS_SP_STEP && memCmd.addr == sp
    && memCmd.write && memReq)
    else $error("push did not write at the lowered pointer");

a_flags_kept: assert property ( // [RULE_06]
    @(posedge clk_sys) disable iff (!reset_n)
    state == ST_READ && memAck && cmd.op != OP_INTERRUPT_RETURN
    |=> sr == $past(sr))
    else $error("pop or return changed the status word");

a_mode_kept: assert property ( // [RULE_07]
    @(posedge clk_sys) disable iff (!reset_n)
    startFire && newCmd.op != OP_INTERRUPT_RETURN && newCmd.op != OP_NONE
    |=> $stable(sr[`CS_BIT_OSCILLATOR_OFF_BIT:`CS_BIT_GIE]))
    else $error("mode bits changed by push or shift");

a_ret_pc: assert property ( // [RULE_08]
    @(posedge clk_sys) disable iff (!reset_n)
    state == ST_READ && memAck && cmd.op == OP_RET
    |=> pc == $past(memRdata) && sp == $past(sp) + `CS_SP_STEP)
    else $error("return did not load counter from stack");

a_interrupt_return_walk: assert property ( // [RULE_09]
    @(posedge clk_sys) disable iff (!reset_n)
    state == ST_READ && memAck && cmd.op == OP_INTERRUPT_RETURN
    |=> sr == $past(memRdata) && state == ST_READ2
    && memCmd.addr == sp)
    else $error("interrupt return did not restore status first");

a_interrupt_return_pc: assert property ( // [RULE_10]
    @(posedge clk_sys) disable iff (!reset_n)
    state == ST_READ2 && memAck
    |=> pc == $past(memRdata) && sp == $past(sp) + `CS_SP_STEP
    && state == ST_IDLE)
    else $error("interrupt return did not load counter second");

a_shl_ovf: assert property ( // [RULE_13]
    @(posedge clk_sys) disable iff (!reset_n)
    startFire && newCmd.op == OP_RLA && !newCmd.byteOp
    |=> sr[`CS_BIT_V] == ($past(operand) >= 16'h4000
    && $past(operand) < 16'hC000)
    && sr[`CS_BIT_C] == $past(operand[15]))
    else $error("word left shift overflow or carry wrong");

a_rra_flags: assert property ( // [RULE_18]
    @(posedge clk_sys) disable iff (!reset_n)
    startFire && newCmd.op == OP_RRA
    |=> !sr[`CS_BIT_V] && sr[`CS_BIT_C] == $past(operand[0]))
    else $error("right shift carry or overflow wrong");

a_wdt_flag: assert property ( // [RULE_20]
    @(posedge clk_sys) disable iff (!reset_n)
    wdtHit |=> wdtViolation && wdtSticky)
    else $error("keyless watchdog write not flagged");

endmodule

// >>> src/cssop_defs.svh
`ifndef CSSOP_DEFS_SVH
`define CSSOP_DEFS_SVH
// How it works
// [RULE_01] pop reads word at stack pointer into destination, then adds 2
// [RULE_02] byte pop into a register keeps low byte, clears high byte
// [RULE_03] word and byte pops both step the stack pointer by exactly two
// [RULE_04] push subtracts 2 from stack pointer, then writes source there
// [RULE_05] word and byte pushes both step the stack pointer down by two
// [RULE_06] pop, push and return leave N, Z, C and V untouched
// [RULE_07] push and shifts leave oscillator-off, core-off and GLOBAL_INTERRUPT_ENABLE untouched
// [RULE_08] return loads program counter from top of stack, then adds 2
// [RULE_09] interrupt return first loads status from stack, adds 2 to pointer
// [RULE_10] interrupt return then loads program counter, adds 2 again
// [RULE_11] interrupt return restores all flags and mode bits from stack
// [RULE_12] left shift moves bits up, old MSB to carry, zero into LSB
// [RULE_13] word left shifts set V for operands 4000h up to below C000h
// [RULE_14] byte left shifts set V for operands 40h up to below C0h
// [RULE_15] left shifts set N, Z from result and carry from old MSB
// [RULE_16] rotate left puts old carry in LSB, old MSB in carry
// [RULE_17] right shift keeps MSB, copies it down, old LSB to carry
// [RULE_18] right shift sets N, Z from result, carry from LSB, clears V
// [RULE_19] byte right shift into a register clears the high byte
// [RULE_20] keyless write to watchdog word at 120h flags a violation

// register byte offsets
`define CS_REG_CTRL 8'h00
`define CS_REG_OPND 8'h04
`define CS_REG_SP 8'h08
`define CS_REG_PC 8'h0C
`define CS_REG_SR 8'h10
`define CS_REG_RES 8'h14
`define CS_REG_STAT 8'h18
// control and status fields
`define CS_CTRL_BYTE 3
`define CS_CTRL_DREG 4
`define CS_CTRL_START 31
`define CS_STAT_BUSY 0
`define CS_STAT_WDT 1
// status word bit positions
`define CS_BIT_C 0
`define CS_BIT_Z 1
`define CS_BIT_N 2
`define CS_BIT_GIE 3
`define CS_BIT_CORE_OFF_BIT 4
`define CS_BIT_OSCILLATOR_OFF_BIT 5
`define CS_BIT_V 8
// reset values
`define CS_SP_RST 16'h0000
`define CS_PC_RST 16'h0000
`define CS_SR_RST 16'h0000
// arithmetic constants
`define CS_SP_STEP 16'h0002
`define CS_HI_CLEAR 8'h00
`define CS_OVF_LO_W 16'h4000
`define CS_OVF_HI_W 16'hC000
`define CS_OVF_LO_B 8'h40
`define CS_OVF_HI_B 8'hC0
// watchdog guard
`define CS_WDT_ADDR 16'h0120
`define CS_WDT_KEY 8'h5A
// bus answers
`define CS_RESP_OKAY 2'h0
`define CS_RESP_SLVERR 2'h2
`endif

// >>> src/cssop_pkg.sv
package cssop_pkg;
    // operation codes written to the control register
    typedef enum logic [2:0] {
        OP_POP = 3'h0,
        OP_PUSH = 3'h1,
        OP_RET = 3'h2,
        OP_INTERRUPT_RETURN = 3'h3,
        OP_RLA = 3'h4,
        OP_RLC = 3'h5,
        OP_RRA = 3'h6,
        OP_NONE = 3'h7
    } cssop_op_t;
    // engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_READ = 2'h1,
        ST_WRITE = 2'h2,
        ST_READ2 = 2'h3
    } cssop_state_t;
    // latched command
    typedef struct packed {
        logic destReg;
        logic byteOp;
        cssop_op_t op;
    } cssop_cmd_t;
    // request toward data memory
    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } cssop_mreq_t;
endpackage

// >>> test/cssop_mem_model.sv
`timescale 1ns/100ps
module cssop_mem_model
    import cssop_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // engine side
    input wire logic memReq,
    input wire cssop_mreq_t memCmd,
    input wire logic [3:0] ackDelay,
    output logic memAck,
    output logic [15:0] memRdata
);
    logic [15:0] store [0:255];
    logic [3:0] waitCnt;

    // ack after ackDelay edges; rdata toggles between acks
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            memAck <= 1'b0;
            waitCnt <= 4'h0;
            memRdata <= 16'hA5A5;
        end else if (memReq && !memAck && waitCnt >= ackDelay) begin
            memAck <= 1'b1;
            waitCnt <= 4'h0;
            memRdata <= store[memCmd.addr[8:1]];
            if (memCmd.write) store[memCmd.addr[8:1]] <= memCmd.wdata;
        end else begin
            memAck <= 1'b0;
            waitCnt <= (memReq && !memAck) ? waitCnt + 4'h1 : 4'h0;
            memRdata <= ~memRdata;
        end
    end
endmodule

// >>> test/cssop_core_tb_top.sv
`timescale 1ns/100ps
`include "cssop_defs.svh"
module cssop_core_tb_top
    import cssop_pkg::*;
;
    logic clk_sys, reset_n, memReq, memAck, wdtViolation;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, ackDelay;
    logic [1:0] s_axi_bresp, s_axi_rresp, lastResp;
    logic [15:0] memRdata;
    cssop_mreq_t memCmd;
    int miscompares, n_tests, wdtCount;

    cssop_core cssop_core_inst (
        .clk_sys, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .memReq, .memCmd, .memRdata, .memAck,
        .wdtViolation
    );
    cssop_mem_model cssop_mem_model_inst (
        .clk_sys, .reset_n, .memReq, .memCmd, .ackDelay, .memAck, .memRdata
    );

    // 125 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // count watchdog pulses
    always @(posedge clk_sys) begin
        if (wdtViolation === 1'b1) wdtCount++;
    end

    // ----------------------------------------
    // reporting and bus tasks
    // ----------------------------------------
    task automatic end_sim();
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic give_up();
        miscompares++;
        end_sim();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // readies sampled mid-cycle
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic tA, tW, tB;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        tB = 1'b0;
        for (int i = 0; i < 40 && !tB; i++) begin
            @(negedge clk_sys);
            tA = s_axi_awvalid && s_axi_awready;
            tW = s_axi_wvalid && s_axi_wready;
            tB = s_axi_bvalid;
            lastResp = s_axi_bresp;
            @(posedge clk_sys);
            if (tA) s_axi_awvalid <= 1'b0;
            if (tW) s_axi_wvalid <= 1'b0;
            if (tB) s_axi_bready <= 1'b0;
        end
        if (!tB) give_up();
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        logic tA, tR;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        tR = 1'b0;
        for (int i = 0; i < 40 && !tR; i++) begin
            @(negedge clk_sys);
            tA = s_axi_arvalid && s_axi_arready;
            tR = s_axi_rvalid;
            d = s_axi_rdata;
            lastResp = s_axi_rresp;
            @(posedge clk_sys);
            if (tA) s_axi_arvalid <= 1'b0;
            if (tR) s_axi_rready <= 1'b0;
        end
        if (!tR) give_up();
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        axi_rd(a, d);
        chk(d, exp);
    endtask

    function automatic logic [31:0] cmd(cssop_op_t op, logic b, logic r);
        return {1'h1, 26'h0, r, b, op};
    endfunction

    // start a command, poll busy
    task automatic run(input logic [31:0] c);
        logic [31:0] s;
        axi_wr(`CS_REG_CTRL, c);
        s = 32'h1;
        for (int i = 0; i < 20 && s[`CS_STAT_BUSY]; i++)
            axi_rd(`CS_REG_STAT, s);
        if (s[`CS_STAT_BUSY] !== 1'b0) give_up();
    endtask

    task automatic push(input logic [15:0] v, input logic b);
        axi_wr(`CS_REG_OPND, {16'h0, v});
        run(cmd(OP_PUSH, b, 1'b0));
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic sc_reset();
        logic [31:0] d;
        rdc(`CS_REG_SP, 32'h0);
        rdc(`CS_REG_PC, 32'h0);
        rdc(`CS_REG_SR, 32'h0);
        rdc(`CS_REG_CTRL, 32'h7);
        rdc(`CS_REG_STAT, 32'h0);
        axi_rd(8'h1C, d);
        chk({30'h0, lastResp}, {30'h0, `CS_RESP_SLVERR});
        chk(d, 32'h0);
        axi_wr(8'h1C, 32'h1);
        chk({30'h0, lastResp}, {30'h0, `CS_RESP_SLVERR});
        axi_wr(`CS_REG_RES, 32'h1234);
        rdc(`CS_REG_RES, 32'h0);
    endtask

    // prompt and slow memory, word and byte forms
    task automatic sc_stack();
        axi_wr(`CS_REG_SR, 32'h013F);
        axi_wr(`CS_REG_SP, 32'h0200);
        push(16'hA5C3, 1'b0);
        rdc(`CS_REG_SP, 32'h01FE);
        ackDelay <= 4'h6;
        push(16'h1234, 1'b0);
        rdc(`CS_REG_SP, 32'h01FC);
        run(cmd(OP_POP, 1'b1, 1'b1));
        rdc(`CS_REG_RES, 32'h0034);
        rdc(`CS_REG_SP, 32'h01FE);
        run(cmd(OP_POP, 1'b0, 1'b1));
        rdc(`CS_REG_RES, 32'hA5C3);
        rdc(`CS_REG_SP, 32'h0200);
        push(16'h77AB, 1'b1);
        rdc(`CS_REG_SP, 32'h01FE);
        run(cmd(OP_POP, 1'b0, 1'b1));
        rdc(`CS_REG_RES, 32'h00AB);
        rdc(`CS_REG_SR, 32'h013F);
    endtask

    task automatic sc_returns();
        ackDelay <= 4'h2;
        axi_wr(`CS_REG_SP, 32'h0300);
        push(16'h4444, 1'b0);
        push(16'h0127, 1'b0);
        axi_wr(`CS_REG_SR, 32'h0);
        run(cmd(OP_INTERRUPT_RETURN, 1'b0, 1'b0));
        rdc(`CS_REG_SR, 32'h0127);
        rdc(`CS_REG_PC, 32'h4444);
        rdc(`CS_REG_SP, 32'h0300);
        ackDelay <= 4'h0;
        push(16'h1A2B, 1'b0);
        run(cmd(OP_RET, 1'b0, 1'b0));
        rdc(`CS_REG_PC, 32'h1A2B);
        rdc(`CS_REG_SP, 32'h0300);
        rdc(`CS_REG_SR, 32'h0127);
    endtask

    // expectations from the shift rules
    task automatic shift(input cssop_op_t op, input logic b, input logic r,
                         input logic [15:0] o, input logic [15:0] sr);
        logic [15:0] res, x, s;
        logic c, v;
        x = b ? {8'h00, o[7:0]} : o;
        c = b ? o[7] : o[15];
        v = b ? (o[7:0] >= 8'h40 && o[7:0] < 8'hC0)
              : (o >= 16'h4000 && o < 16'hC000);
        res = (x << 1) | {15'h0, op == OP_RLC && sr[`CS_BIT_C]};
        if (op == OP_RRA) begin
            res = b ? {8'h00, o[7], o[7:1]} : {o[15], o[15:1]};
            c = o[0];
            v = 1'b0;
        end
        if (b) res = {r ? 8'h00 : o[15:8], res[7:0]};
        s = sr;
        s[`CS_BIT_C] = c;
        s[`CS_BIT_V] = v;
        s[`CS_BIT_N] = b ? res[7] : res[15];
        s[`CS_BIT_Z] = b ? (res[7:0] == 8'h00) : (res == 16'h0000);
        axi_wr(`CS_REG_SR, {16'h0, sr});
        axi_wr(`CS_REG_OPND, {16'h0, o});
        run(cmd(op, b, r));
        rdc(`CS_REG_RES, {16'h0, res});
        rdc(`CS_REG_SR, {16'h0, s});
    endtask

    task automatic sc_shifts();
        shift(OP_RLA, 1'b0, 1'b1, 16'h4000, 16'h0038);
        shift(OP_RLA, 1'b0, 1'b1, 16'hBFFF, 16'h0000);
        shift(OP_RLA, 1'b0, 1'b1, 16'hC000, 16'h0100);
        shift(OP_RLA, 1'b0, 1'b1, 16'h3FFF, 16'h0000);
        shift(OP_RLA, 1'b0, 1'b1, 16'h8000, 16'h0004);
        shift(OP_RLA, 1'b1, 1'b1, 16'hFF40, 16'h0000);
        shift(OP_RLA, 1'b1, 1'b1, 16'h00C0, 16'h0100);
        shift(OP_RLC, 1'b0, 1'b1, 16'h4001, 16'h0001);
        shift(OP_RLC, 1'b1, 1'b0, 16'h12BF, 16'h0039);
        shift(OP_RRA, 1'b0, 1'b1, 16'h8001, 16'h0100);
        shift(OP_RRA, 1'b0, 1'b1, 16'h0001, 16'h0100);
        shift(OP_RRA, 1'b1, 1'b1, 16'h1281, 16'h0138);
    endtask

    // keyless watchdog writes, one a same-value copy
    task automatic sc_watchdog();
        wdtCount = 0;
        axi_wr(`CS_REG_SP, 32'h0122);
        push(16'h1234, 1'b0);
        chk(wdtCount, 32'h1);
        rdc(`CS_REG_STAT, 32'h2);
        axi_wr(`CS_REG_STAT, 32'h2);
        rdc(`CS_REG_STAT, 32'h0);
        axi_wr(`CS_REG_SP, 32'h0122);
        push(16'h1234, 1'b0);
        chk(wdtCount, 32'h2);
        axi_wr(`CS_REG_SP, 32'h0122);
        push(16'h5A34, 1'b0);
        push(16'h1234, 1'b0);
        chk(wdtCount, 32'h2);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        reset_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready} = 2'b00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        ackDelay = 4'h0;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        sc_reset();
        sc_stack();
        sc_returns();
        sc_shifts();
        sc_watchdog();
        end_sim();
    end
endmodule
